// *** src/pfh_pkg.sv ***
// package for the page flash host controller: pin timing, commands, carriers
package pfh_pkg;
  // bus widths
  localparam int ADDR_W      = 20;
  localparam int DATA_W      = 16;
  localparam int LANE_W      = 8;
  // unlock addresses, compared on address bits 14..0 only
  localparam int UNLOCK_W    = 15;
  localparam logic [14:0] UNLOCK_A1 = 15'h5555;
  localparam logic [14:0] UNLOCK_A2 = 15'h2AAA;
  localparam logic [7:0]  UNLOCK_D1 = 8'hAA;
  localparam logic [7:0]  UNLOCK_D2 = 8'h55;
  // command bytes sent on the third write; erase confirm bytes go on the sixth
  localparam logic [7:0]  CMD_READ_RESET  = 8'hF0;
  localparam logic [7:0]  CMD_PROGRAM     = 8'hA0;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  CMD_CHIP_ERASE  = 8'h10;
  localparam logic [7:0]  CMD_SECT_ERASE  = 8'h30;
  localparam logic [7:0]  CMD_SUSPEND     = 8'hB0;
  localparam logic [7:0]  CMD_RESUME      = 8'hD0;
  localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
  localparam logic [7:0]  CMD_CLR_STATUS  = 8'h50;
  // page geometry
  localparam int PAGE_WORDS  = 64;
  localparam int PAGE_BYTES  = 128;
  localparam int RPAGE_W     = 3;
  // strobe timing: phase length in ns and cycles at 10 MHz
  localparam int CLK_NS      = 100;
  localparam int PHASE_NS    = 200;
  localparam int PHASE_CYC   = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 4;

  // user operations
  typedef enum logic [2:0] {
    PFH_OP_READ, PFH_OP_WRITE, PFH_OP_CMD, PFH_OP_ERASE, PFH_OP_CMD_DATA
  } pfh_op_t;

  // request carrier
  typedef struct packed {
    pfh_op_t           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [7:0]        cmd;
    logic              byte_lo;
  } pfh_req_t;

  // flash pin carrier (outputs of the controller)
  typedef struct packed {
    logic [ADDR_W-1:0] addr_in;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic              byte_n;
    logic              wp;
  } pfh_pins_t;
endpackage

// *** src/pfh_host.sv ***
// host controller driving a page-mode parallel flash through its pins
// How it works
// RQ1 - address presented per write, dropped after
// RQ2 - commands and status on low lane
// RQ3 - device floats lanes when deselected
// RQ4 - upper lane written only word writes
// RQ5 - byte mode: top pin is address
// RQ6 - word mode: top pin carries data
// RQ7 - chip select low for every access
// RQ8 - output enable low only when reading
// RQ9 - commands written by write enable strobe
// RQ10 - device protects top and bottom sectors
// RQ11 - write protect pin high unlocks all
// RQ12 - page reads vary three low addresses; host reads one word per request, CE_N raised after each
// RQ13 - page program latches one page; host programs one word per write sequence
// RQ14 - erase one sector or chip
// RQ15 - erase suspend command supported
// RQ16 - status register polled for completion
// RQ17 - unlock addresses 5555 and 2AAA
// RQ18 - command data on low byte only
// RQ19 - only status or suspend while busy; host takes no request while BUSY_OP, then any op once idle
// RQ20 - address at fall, data at rise
`timescale 1ns/1ns
module pfh_host
  import pfh_pkg::*;
#(
  parameter int PHASE = PHASE_CYC
) (
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic              REQ_VALID,
  input  wire pfh_op_t           REQ_OP,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic [DATA_W-1:0] REQ_DATA,
  input  wire logic [7:0]        REQ_CMD,
  input  wire logic              WORD_MODE,
  input  wire logic              UNPROTECT,
  output logic                   REQ_READY,
  output logic                   RSP_VALID,
  output logic [DATA_W-1:0]      RSP_DATA,
  output logic                   BUSY_OP,
  output logic [ADDR_W-1:0]      ADDR_IN,
  output logic                   CE_N,
  output logic                   OE_N,
  output logic                   WE_N,
  output logic                   BYTE_N,
  output logic                   WP,
  output logic [LANE_W-1:0]      LOW_LANE_O,
  output logic                   LOW_LANE_OE_N,
  input  wire logic [LANE_W-1:0] LOW_LANE_I,
  output logic [6:0]             UPPER_LANE_O,
  output logic                   UPPER_LANE_OE_N,
  input  wire logic [6:0]        UPPER_LANE_I,
  output logic                   TOP_DATA_OR_LOW_ADDR_O,
  output logic                   TOP_DATA_OR_LOW_ADDR_OE_N,
  input  wire logic              TOP_DATA_OR_LOW_ADDR_I
);

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_NEXT} pfh_state_t;

  pfh_state_t        state_r, state_nxt;
  pfh_req_t          req_r;
  logic [2:0]        step_r;         // bus cycle index within a sequence
  logic [2:0]        nsteps_r;       // total bus cycles in sequence
  logic [CNT_W-1:0]  cnt_r;
  logic              word_r;
  logic [ADDR_W-1:0] cyc_addr;
  logic [7:0]        cyc_lo;
  logic [DATA_W-1:0] cyc_data;
  logic              cyc_is_read;
  logic              cyc_wide;
  logic              phase_done;
  logic [DATA_W-1:0] rd_word;
  logic              busy_r;
  logic [ADDR_W-1:0] pin_addr_r;

  // count of bus cycles for each operation
  function automatic logic [2:0] op_steps(input pfh_op_t op);
    unique case (op)
      PFH_OP_READ:     op_steps = 3'd1;
      PFH_OP_WRITE:    op_steps = 3'd4;
      PFH_OP_CMD:      op_steps = 3'd3;
      PFH_OP_ERASE:    op_steps = 3'd6;
      PFH_OP_CMD_DATA: op_steps = 3'd4;
      default:         op_steps = 3'd1;
    endcase
  endfunction

  // unlock prefix address for a step, upper bits zero
  function automatic logic [ADDR_W-1:0] pre_addr(input logic [2:0] s);
    pre_addr = {(ADDR_W-UNLOCK_W)'(0), (s == 3'd1 || s == 3'd4) ? UNLOCK_A2 : UNLOCK_A1};
  endfunction

  // per-step address and data selection
  // RQ17 unlock address decode
  // status sequences end in a read cycle on their fourth step
  assign cyc_is_read = (req_r.op == PFH_OP_READ) || (req_r.op == PFH_OP_CMD_DATA && step_r == 3'd3);
  assign cyc_addr = cyc_is_read ? req_r.addr
                  : (step_r == nsteps_r - 3'd1 && req_r.op != PFH_OP_CMD) ? req_r.addr
                  : pre_addr(step_r);
  // RQ18 command on low byte
  assign cyc_lo = (step_r == 3'd0 || step_r == 3'd3) ? UNLOCK_D1
                : (step_r == 3'd1 || step_r == 3'd4) ? UNLOCK_D2
                : (step_r == 3'd2 && req_r.op == PFH_OP_ERASE) ? CMD_ERASE_SETUP
                : req_r.cmd;
  assign cyc_data = (req_r.op == PFH_OP_WRITE && step_r == 3'd3) ? req_r.data
                  : (req_r.op == PFH_OP_ERASE && step_r == 3'd5) ? {8'h00, req_r.cmd}
                  : {8'h00, cyc_lo};
  // RQ4 upper lane only for word data writes
  assign cyc_wide = word_r && req_r.op == PFH_OP_WRITE && step_r == 3'd3;
  assign phase_done = (cnt_r == CNT_W'(PHASE - 1));
  // RQ5 byte mode reads only the low lane
  assign rd_word = word_r ? {TOP_DATA_OR_LOW_ADDR_I, UPPER_LANE_I, LOW_LANE_I}
                          : {8'h00, LOW_LANE_I};

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      S_IDLE:   if (REQ_VALID) state_nxt = S_SETUP;
      S_SETUP:  if (phase_done) state_nxt = S_STROBE;
      S_STROBE: if (phase_done) state_nxt = S_HOLD;
      S_HOLD:   if (phase_done) state_nxt = (step_r == nsteps_r - 3'd1) ? S_IDLE : S_NEXT;
      S_NEXT:   state_nxt = S_SETUP;
    endcase
  end

  // sequencer registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_r  <= S_IDLE;
      cnt_r    <= '0;
      step_r   <= '0;
      nsteps_r <= '0;
      req_r    <= '0;
      word_r   <= 1'b1;
      busy_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (state_nxt != state_r) ? '0 : cnt_r + CNT_W'(1);
      if (state_r == S_IDLE && REQ_VALID) begin
        req_r    <= '{op: REQ_OP, addr: REQ_ADDR, data: REQ_DATA, cmd: REQ_CMD, byte_lo: 1'b0};
        nsteps_r <= op_steps(REQ_OP);
        step_r   <= '0;
        word_r   <= WORD_MODE;
        busy_r   <= 1'b1;
      end
      if (state_r == S_NEXT) step_r <= step_r + 3'd1;
      if (state_r == S_HOLD && state_nxt == S_IDLE) busy_r <= 1'b0;
    end
  end

  // pin registers: address lags the step by one clock, so it settles one cycle into setup and holds through hold
  always_ff @(posedge MCLK) begin
    if (RST) begin
      pin_addr_r <= '0;
      CE_N       <= 1'b1;
      OE_N       <= 1'b1;
      WE_N       <= 1'b1;
      RSP_VALID  <= 1'b0;
      RSP_DATA   <= '0;
      LOW_LANE_O <= '0;
      UPPER_LANE_O <= '0;
      TOP_DATA_OR_LOW_ADDR_O <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      // RQ1 address per cycle
      pin_addr_r <= cyc_addr;
      // RQ7 chip select around access
      CE_N <= (state_nxt == S_IDLE || state_nxt == S_NEXT);
      // RQ8 output enable for reads
      OE_N <= !(cyc_is_read && state_nxt == S_STROBE);
      // RQ9 RQ20 write strobe, address at fall, data at rise
      WE_N <= !(!cyc_is_read && state_nxt == S_STROBE);
      LOW_LANE_O   <= cyc_data[LANE_W-1:0];
      UPPER_LANE_O <= cyc_data[14:8];
      // byte mode: top pin picks the byte on reads and on program data alike
      TOP_DATA_OR_LOW_ADDR_O <= word_r ? cyc_data[15] : req_r.addr[0];
      // RQ2 RQ16 sample read data at end of strobe
      if (state_r == S_STROBE && phase_done && cyc_is_read) begin
        RSP_VALID <= 1'b1;
        RSP_DATA  <= rd_word;
      end
    end
  end

  // output drives; enables active low
  // RQ6 top pin is data in word mode, address in byte mode
  assign ADDR_IN   = pin_addr_r;
  assign LOW_LANE_OE_N   = !(!cyc_is_read && state_r != S_IDLE);
  assign UPPER_LANE_OE_N = !(!cyc_is_read && state_r != S_IDLE && cyc_wide);
  assign TOP_DATA_OR_LOW_ADDR_OE_N = word_r ? UPPER_LANE_OE_N : 1'b0;
  assign BYTE_N    = word_r;
  // RQ11 write protect pin from user
  assign WP        = UNPROTECT;
  // RQ19 one request at a time while busy
  assign REQ_READY = (state_r == S_IDLE);
  assign BUSY_OP   = busy_r;

  // RQ8 output enable never low with write enable
  property p_oe_we_excl;
    @(posedge MCLK) disable iff (RST) !(OE_N == 1'b0 && WE_N == 1'b0);
  endproperty
  a_oe_we_excl: assert property (p_oe_we_excl) else $error("oe and we low together"); // RQ8

  // RQ7 strobes only with chip selected
  property p_ce_strobe;
    @(posedge MCLK) disable iff (RST) (!WE_N || !OE_N) |-> !CE_N;
  endproperty
  a_ce_strobe: assert property (p_ce_strobe) else $error("strobe without chip select"); // RQ7

  // RQ20 address stable across write strobe
  property p_addr_stable;
    @(posedge MCLK) disable iff (RST) !WE_N |-> $stable(ADDR_IN);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved under strobe"); // RQ20

  // RQ3 host not driving low lane during read strobe
  property p_no_contention;
    @(posedge MCLK) disable iff (RST) !OE_N |-> LOW_LANE_OE_N;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("host drives lane in read"); // RQ3

  // RQ17 first write of command goes to unlock address
  property p_unlock_first;
    @(posedge MCLK) disable iff (RST)
      ($fell(WE_N) && step_r == 3'd0) |-> ADDR_IN[14:0] == UNLOCK_A1 && LOW_LANE_O == UNLOCK_D1;
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("bad first unlock cycle"); // RQ17

  // RQ5 top pin driven as address in byte mode
  property p_byte_top;
    @(posedge MCLK) disable iff (RST) !BYTE_N |-> !TOP_DATA_OR_LOW_ADDR_OE_N;
  endproperty
  a_byte_top: assert property (p_byte_top) else $error("top pin floating in byte mode"); // RQ5

  // RQ2 read response follows output enable
  property p_rsp_after_oe;
    @(posedge MCLK) disable iff (RST) RSP_VALID |-> $past(!OE_N);
  endproperty
  a_rsp_after_oe: assert property (p_rsp_after_oe) else $error("response without read strobe"); // RQ2

  // RQ9 strobe lasts phase length
  property p_we_width;
    @(posedge MCLK) disable iff (RST) $fell(WE_N) |-> !WE_N [*2];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe too short"); // RQ9

endmodule // pfh_host

// *** bench/pfh_flash_model.sv ***
// behavioural flash device model answering the host controller's pin cycles
`timescale 1ns/1ns
module pfh_flash_model
  import pfh_pkg::*;
(
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic              CE_N,
  input  wire logic              OE_N,
  input  wire logic              WE_N,
  input  wire logic              BYTE_N,
  input  wire logic              WP,
  input  wire logic [DATA_W-1:0] DQ_I,
  output logic [DATA_W-1:0]      DQ_O,
  output logic                   DRV_LO,
  output logic                   DRV_HI
);
  logic [DATA_W-1:0] mem [16];
  logic [ADDR_W-1:0] a_lat;
  logic              t_lat;
  logic [2:0]        step;
  logic              prog;
  logic              stat;
  logic [7:0]        last_cmd;
  logic [7:0]        erase_cmd;
  logic [4:0]        erase_sect;
  logic              erase_ok;
  // in-page word picked by low address bits
  wire  [3:0]        idx = ADDR_IN[3:0];
  wire  [7:0]        d   = DQ_I[7:0];
  wire               ua1 = a_lat[14:0] == UNLOCK_A1;
  wire               ua2 = a_lat[14:0] == UNLOCK_A2;
  wire  [7:0]        rb  = DQ_I[15] ? mem[idx][15:8] : mem[idx][7:0];
  // preset array with a pattern tied to the word index
  initial begin
    step = 0; prog = 0; stat = 0; last_cmd = 0; erase_cmd = 0; erase_sect = 0;
    erase_ok = 1;
    for (int i = 0; i < 16; i++) mem[i] = {4'h9, 4'(i), 4'h6, 4'(i)};
  end
  // drive only when selected and enabled
  assign DRV_LO = !CE_N && !OE_N;
  // upper lanes only in word reads
  assign DRV_HI = DRV_LO && BYTE_N && !stat;
  assign DQ_O   = stat ? 16'h0080 : BYTE_N ? mem[idx] : {8'h00, rb};
  always @(negedge WE_N) if (!CE_N) begin
    a_lat = ADDR_IN;
    t_lat = DQ_I[15];
  end
  always @(posedge WE_N) if (!CE_N) begin
    if (prog) begin
      if (BYTE_N) mem[a_lat[3:0]] = DQ_I;
      else if (t_lat) mem[a_lat[3:0]][15:8] = d;
      else mem[a_lat[3:0]][7:0] = d;
      prog = 0;
    end else if ((step == 0 || step == 3) && ua1 && d == UNLOCK_D1) step = step + 1;
    else if ((step == 1 || step == 4) && ua2 && d == UNLOCK_D2) step = step + 1;
    else if (step == 2 && ua1 && d == CMD_ERASE_SETUP) step = 3;
    else if (step == 2 && ua1) begin
      last_cmd = d;
      prog = d == CMD_PROGRAM;
      stat = d == CMD_READ_STATUS;
      step = 0;
    end else if (step == 5) begin
      erase_cmd = d;
      erase_sect = a_lat[19:15];
      // end sectors refuse sector erase unless protect pin high
      erase_ok = WP || d != CMD_SECT_ERASE || (a_lat[19:15] != 5'h1F && a_lat[19:15] != 5'h00);
      step = 0;
    end else step = 0;
  end
endmodule // pfh_flash_model

// *** bench/page_flash_host_interface_test.sv ***
// self-checking bench for the page flash host controller
`timescale 1ns/1ns
module page_flash_host_interface_test
  import pfh_pkg::*;
;
  logic MCLK = 0, RST = 1, REQ_VALID = 0, WORD_MODE = 1, UNPROTECT = 0;
  pfh_op_t REQ_OP = PFH_OP_READ;
  logic [ADDR_W-1:0] REQ_ADDR = '0, ADDR_IN;
  logic [DATA_W-1:0] REQ_DATA = '0, RSP_DATA, m_o, rd;
  logic [7:0] REQ_CMD = '0, low_o;
  logic [6:0] up_o;
  logic REQ_READY, RSP_VALID, BUSY_OP, CE_N, OE_N, WE_N, BYTE_N, WP, low_oe_n, up_oe_n, top_o, top_oe_n, m_lo, m_hi;
  int bad_count = 0, total_checks = 0;
  // resolve shared lanes; a released lane shows a toggling pattern
  wire [7:0] low = !low_oe_n ? low_o : m_lo ? m_o[7:0] : {8{MCLK}} ^ 8'h5A;
  wire [6:0] up  = !up_oe_n ? up_o : m_hi ? m_o[14:8] : {7{MCLK}} ^ 7'h2A;
  wire       top = !top_oe_n ? top_o : m_hi ? m_o[15] : MCLK;
  always #50 MCLK = ~MCLK;
  pfh_host dut (.MCLK(MCLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR),
    .REQ_DATA(REQ_DATA), .REQ_CMD(REQ_CMD), .WORD_MODE(WORD_MODE), .UNPROTECT(UNPROTECT), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .RSP_DATA(RSP_DATA), .BUSY_OP(BUSY_OP), .ADDR_IN(ADDR_IN), .CE_N(CE_N), .OE_N(OE_N),
    .WE_N(WE_N), .BYTE_N(BYTE_N), .WP(WP), .LOW_LANE_O(low_o), .LOW_LANE_OE_N(low_oe_n), .LOW_LANE_I(low),
    .UPPER_LANE_O(up_o), .UPPER_LANE_OE_N(up_oe_n), .UPPER_LANE_I(up), .TOP_DATA_OR_LOW_ADDR_O(top_o),
    .TOP_DATA_OR_LOW_ADDR_OE_N(top_oe_n), .TOP_DATA_OR_LOW_ADDR_I(top));
  pfh_flash_model m (.ADDR_IN(ADDR_IN), .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .BYTE_N(BYTE_N), .WP(WP),
    .DQ_I({top, up, low}), .DQ_O(m_o), .DRV_LO(m_lo), .DRV_HI(m_hi));
  // compare and report
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one request, held until taken, then wait for completion
  task automatic req(input pfh_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dt,
                     input logic [7:0] c);
    REQ_OP = op; REQ_ADDR = a; REQ_DATA = dt; REQ_CMD = c; REQ_VALID = 1;
    do @(posedge MCLK); while (REQ_READY !== 1);
    #10 REQ_VALID = 0;
    for (int i = 0; i < 300; i++) begin
      if (RSP_VALID === 1) rd = RSP_DATA;
      if (i > 0 && REQ_READY === 1 && BUSY_OP === 0) break;
      @(posedge MCLK); #10;
    end
  endtask
  // no contention while flash output enabled
  always @(negedge MCLK) if (!RST && OE_N === 0) begin
    check({WE_N, CE_N, low_oe_n, up_oe_n}, 16'h000B);
  end
  task automatic t_reset();
    check({CE_N, OE_N, WE_N, BYTE_N, low_oe_n, up_oe_n, top_oe_n}, 16'h007F);
    $display("test reset done");
  endtask
  task automatic t_prog();
    req(PFH_OP_WRITE, 20'h0_0007, 16'hBEEF, CMD_PROGRAM);
    check(m.last_cmd, CMD_PROGRAM);
    req(PFH_OP_READ, 20'h0_0007, '0, '0);
    check(rd, 16'hBEEF);
    req(PFH_OP_READ, 20'h0_0003, '0, '0);
    check(rd, 16'h9363);
    req(PFH_OP_READ, 20'h0_0001, '0, '0);
    check(rd, 16'h9161);
    $display("test program done");
  endtask
  task automatic t_byte();
    WORD_MODE = 0;
    req(PFH_OP_READ, 20'h0_0002, '0, '0);
    check(rd[7:0], 8'h62);
    req(PFH_OP_READ, 20'h0_0005, '0, '0);
    check(rd[7:0], 8'h95);
    req(PFH_OP_WRITE, 20'h0_0005, 16'h00A5, CMD_PROGRAM);
    req(PFH_OP_READ, 20'h0_0005, '0, '0);
    check(rd[7:0], 8'hA5);
    check(BYTE_N, 1'b0);
    WORD_MODE = 1;
    $display("test byte done");
  endtask
  task automatic t_status();
    req(PFH_OP_CMD_DATA, '0, '0, CMD_READ_STATUS);
    check(rd[7:0], 8'h80);
    req(PFH_OP_CMD, '0, '0, CMD_READ_RESET);
    check(m.stat, 1'b0);
    $display("test status done");
  endtask
  task automatic t_erase();
    req(PFH_OP_ERASE, 20'hF_8000, '0, CMD_SECT_ERASE);
    check(m.erase_ok, 1'b0);
    UNPROTECT = 1;
    req(PFH_OP_ERASE, 20'hF_8000, '0, CMD_SECT_ERASE);
    check({m.erase_cmd, 3'b000, m.erase_sect}, {CMD_SECT_ERASE, 8'h1F});
    check(m.erase_ok, 1'b1);
    UNPROTECT = 0;
    req(PFH_OP_ERASE, 20'h0_5555, '0, CMD_CHIP_ERASE);
    check(m.erase_cmd, CMD_CHIP_ERASE);
    req(PFH_OP_CMD, '0, '0, CMD_SUSPEND);
    check(m.last_cmd, CMD_SUSPEND);
    req(PFH_OP_CMD, '0, '0, CMD_RESUME);
    check(m.last_cmd, CMD_RESUME);
    req(PFH_OP_CMD, '0, '0, CMD_CLR_STATUS);
    check(m.last_cmd, CMD_CLR_STATUS);
    $display("test erase done");
  endtask
  task automatic t_wp();
    UNPROTECT = 1; #10;
    check(WP, 1'b1);
    UNPROTECT = 0; #10;
    check(WP, 1'b0);
    $display("test protect done");
  endtask
  // watchdog on the whole run
  initial begin
    repeat (20000) @(posedge MCLK);
    bad_count++;
    summarize();
  end
  initial begin
    repeat (6) @(posedge MCLK);
    #10 RST = 0;
    @(posedge MCLK); #10;
    t_reset(); t_prog(); t_byte(); t_status(); t_erase(); t_wp();
    summarize();
  end
endmodule // page_flash_host_interface_test
